// file: logic/cssr_pkg.sv
// Purpose: shared constants for the cell scheduler support registers
// Assumes: one 32-bit word per register, byte addresses on an 8-bit port
// Notes:   offsets, reset values and widths live here, except RM_W and SVC_W on cssr_top

package cssr_pkg;

  // ************************************************************
  // register port and map
  // ************************************************************
  localparam int         ADDR_W       = 8;
  localparam logic [7:0] OFF_ABR_PRE  = 8'h00;
  localparam logic [7:0] OFF_RM_TMR   = 8'h04;
  localparam logic [7:0] OFF_UPD_DAT0 = 8'h08;
  localparam logic [7:0] OFF_UPD_MSK0 = 8'h0c;
  localparam logic [7:0] OFF_UPD_OP0  = 8'h10;
  localparam logic [7:0] OFF_UPD_DAT1 = 8'h14;
  localparam logic [7:0] OFF_UPD_MSK1 = 8'h18;
  localparam logic [7:0] OFF_UPD_OP1  = 8'h1c;
  localparam logic [7:0] OFF_DROP_SEL = 8'h20;
  localparam logic [7:0] OFF_BW_HI    = 8'h24;
  localparam logic [7:0] OFF_BW_MED   = 8'h28;
  localparam logic [7:0] OFF_BW_LOW   = 8'h2c;
  localparam logic [7:0] OFF_TX_HI    = 8'h30;
  localparam logic [7:0] OFF_TX_MED   = 8'h34;
  localparam logic [7:0] OFF_TX_LOW   = 8'h38;
  localparam logic [7:0] OFF_CTRL     = 8'h3c;
  localparam logic [7:0] OFF_STATUS   = 8'h40;
  localparam logic [7:0] OFF_INT_EN   = 8'h44;
  localparam logic [7:0] OFF_TD_PTR   = 8'h48;
  localparam logic [7:0] OFF_TD_DAT   = 8'h4c;
  localparam logic [7:0] OFF_TW_PTR   = 8'h50;
  localparam logic [7:0] OFF_TW_DAT   = 8'h54;
  localparam logic [7:0] OFF_LC_PTR   = 8'h58;
  localparam logic [7:0] OFF_LC_DAT   = 8'h5c;
  localparam logic [7:0] OFF_FSVC_HI  = 8'h60;
  localparam logic [7:0] OFF_SSVC_HI  = 8'h6c;
  localparam logic [7:0] OFF_TSVC     = 8'h78;
  localparam logic [7:0] OFF_BYTES_Q  = 8'h80;
  localparam logic [7:0] OFF_CONG     = 8'hc0;
  localparam logic [7:0] CONG_MASK    = 8'he0;

  // ************************************************************
  // field layout
  // ************************************************************
  localparam int UPD_BUSY_BIT  = 1;
  localparam int CTRL_CONG_WE  = 0;
  localparam int UPD_IDX_LO    = 2;
  localparam int TS_W          = 23;
  localparam int TSVC_HI       = 22;
  localparam int TSVC_LO       = 15;
  localparam int STS_W         = 8;
  localparam int BW_CNT_LO     = 8;

  // ************************************************************
  // sizes
  // ************************************************************
  localparam int ACC_W     = 24;
  localparam int PRIOS     = 3;
  localparam int DROPS     = 4;
  localparam int NBANK     = 12;
  localparam int TD_DEPTH  = 96;
  localparam int TW_DEPTH  = 16384;
  localparam int TW_W      = 19;
  localparam int LC_DEPTH  = 64;
  localparam int CONG_GRPS = 160;
  localparam int CONG_W    = 20;

  // ************************************************************
  // reset values and timing
  // ************************************************************
  localparam longint REF_CLK_PS = 30000;
  localparam longint ABR_TICK_PS = 780000000;
  localparam logic [23:0] ABR_PRE_RST =
    24'((REF_CLK_PS * (64'd1 << 23)) / ABR_TICK_PS);
  localparam logic [15:0] BW_RST = 16'hff01;

  typedef enum logic [2:0] {
    UPD_IDLE = 3'b001,
    UPD_RD   = 3'b010,
    UPD_WR   = 3'b100
  } cssr_upd_t;

endpackage

// file: logic/cssr_top.sv
// Purpose: cell scheduler support logic and its registers
// Assumes: one clock; all event inputs come from logic on sys_clk_i
// Notes:   arrays are swept to zero for 16384 cycles after reset
//
// Function
// - add prescaler into 24-bit accumulator; top bit toggle ticks RM timer
// - prescaler resets to 0.78 ms tick value for a 30 ns clock
// - RM timer is the time reference for last RM cell sent
// - writing the descriptor word address to operation register starts update
// - update reads word, replaces mask-selected bits with data, writes back
// - data and mask accesses and operation writes stall while update runs
// - operation register reads bit 0 as zero, bit 1 as busy
// - data register takes merged word as update completes
// - two independent sets of data, mask and operation registers
// - drop select picks drop for banked serviced and limit registers
// - high limiter: upper-byte cells per lower-byte window, waived if idle below
// - medium limiter same scheme, waived when low has nothing pending
// - low limiter same scheme, never waived
// - three transmitted-cell counters, one per priority
// - twelve 32-bit bytes-queued counters per priority and drop
// - fast-serviced counter mismatch flags pending; increments per service
// - slow-serviced counter mismatch flags pending; increments per service
// - timer-serviced counter versus timeslot bits 22-15; increments per service
// - interrupt only when status, enable and central enable all set
// - timing, time wheel and cache arrays, cleared to zero at power-up
// - array pointers step per data access and wrap after last word
// - 160 congestion groups halt scheduling; 20-bit read groups; gated writes

`timescale 1ns/1ps

module cssr_top #(
  parameter int RM_W  = 16,
  parameter int SVC_W = 16
) (
  input  wire logic                        sys_clk_i,
  input  wire logic                        srst_i,
  input  wire logic                        reg_req_i,
  input  wire logic                        reg_we_i,
  input  wire logic [cssr_pkg::ADDR_W-1:0] reg_addr_i,
  input  wire logic [31:0]                 reg_wdata_i,
  output logic                             reg_ack_o,
  output logic [31:0]                      reg_rdata_o,
  input  wire logic [cssr_pkg::TS_W-1:0]   timeslot_i,
  input  wire logic                        cell_time_i,
  input  wire logic                        cell_sent_i,
  input  wire logic [1:0]                  cell_prio_i,
  input  wire logic [1:0]                  cell_drop_i,
  input  wire logic [15:0]                 cell_bytes_i,
  input  wire logic                        enq_i,
  input  wire logic [1:0]                  enq_prio_i,
  input  wire logic [1:0]                  enq_drop_i,
  input  wire logic [15:0]                 enq_bytes_i,
  input  wire logic [11:0]                 pend_i,
  input  wire logic [2:0]                  fast_svc_i,
  input  wire logic [2:0]                  slow_svc_i,
  input  wire logic [1:0]                  svc_drop_i,
  input  wire logic                        timer_svc_i,
  input  wire logic [5:0]                  cong_qgrp_i,
  input  wire logic [1:0]                  cong_drop_i,
  input  wire logic [cssr_pkg::STS_W-1:0]  sts_evt_i,
  input  wire logic                        central_ien_i,
  output logic [RM_W-1:0]                  rm_timer_o,
  output logic [11:0]                      allow_o,
  output logic [11:0]                      fast_pend_o,
  output logic [11:0]                      slow_pend_o,
  output logic                             timer_pend_o,
  output logic                             halt_o,
  output logic                             irq_o,
  output logic                             clearing_o
);
  import cssr_pkg::*;

  function automatic logic [3:0] bidx(input logic [1:0] p,
                                      input logic [1:0] d);
    return {p, d};
  endfunction

  function automatic logic [13:0] step(input logic [13:0] p,
                                       input logic [13:0] last);
    return (p == last) ? 14'h0000 : p + 14'h0001;
  endfunction

  // ************************************************************
  // state
  // ************************************************************
  logic [ACC_W-1:0] acc_r, acc_nxt, pre_r, pre_nxt;
  logic [RM_W-1:0]  rm_r, rm_nxt;
  logic [31:0]      dat_r [2], dat_nxt [2], msk_r [2], msk_nxt [2];
  cssr_upd_t        st_r, st_nxt;
  logic             set_r, set_nxt;
  logic [5:0]       uadr_r, uadr_nxt;
  logic [31:0]      uword_r, uword_nxt;
  logic [1:0]       drop_r, drop_nxt;
  logic [15:0]      bw_r [NBANK], bw_nxt [NBANK];
  logic [7:0]       win_r [NBANK], win_nxt [NBANK];
  logic [7:0]       sent_r [NBANK], sent_nxt [NBANK];
  logic [31:0]      tx_r [PRIOS], tx_nxt [PRIOS];
  logic [31:0]      bq_r [NBANK], bq_nxt [NBANK];
  logic [SVC_W-1:0] fs_r [NBANK], fs_nxt [NBANK];
  logic [SVC_W-1:0] ss_r [NBANK], ss_nxt [NBANK];
  logic [7:0]       ts_r, ts_nxt;
  logic             cwe_r, cwe_nxt;
  logic [STS_W-1:0] sts_r, sts_nxt, ien_r, ien_nxt;
  logic [6:0]       tptr_r, tptr_nxt;
  logic [13:0]      wptr_r, wptr_nxt;
  logic [5:0]       cptr_r, cptr_nxt;
  logic [CONG_GRPS-1:0] cong_r, cong_nxt;
  logic             clr_r, clr_nxt;
  logic [13:0]      cidx_r, cidx_nxt;
  logic             ack_nxt, halt_nxt, irq_nxt, tp_nxt;
  logic [31:0]      rdat_nxt;
  logic [11:0]      allow_nxt, fp_nxt, sp_nxt;

  logic [31:0]      td_mem [TD_DEPTH];
  logic [TW_W-1:0]  tw_mem [TW_DEPTH];
  logic [31:0]      lc_mem [LC_DEPTH];
  logic             td_we, tw_we, lc_we;
  logic [31:0]      lc_wd, rd_val, merged;
  logic [5:0]       lc_wa;
  logic             take, wr, stall, upd_reg, arr_reg, busy;
  logic [7:0]       grp;

  // ************************************************************
  // register access decode
  // ************************************************************
  always_comb begin
    busy    = (st_r != UPD_IDLE);
    upd_reg = (reg_addr_i >= OFF_UPD_DAT0) && (reg_addr_i <= OFF_UPD_OP1);
    arr_reg = (reg_addr_i == OFF_TD_DAT) || (reg_addr_i == OFF_TW_DAT) ||
              (reg_addr_i == OFF_LC_DAT);
    // op register reads stay open so software can poll busy
    stall = (busy && upd_reg && (reg_we_i ||
              !(reg_addr_i == OFF_UPD_OP0 || reg_addr_i == OFF_UPD_OP1))) ||
            (clr_r && (upd_reg || arr_reg)) ||
            (busy && reg_addr_i == OFF_LC_DAT);
    take = reg_req_i && !reg_ack_o && !stall;
    wr   = take && reg_we_i;
    merged = (uword_r & ~msk_r[set_r]) | (dat_r[set_r] & msk_r[set_r]);
  end

  // ************************************************************
  // read mux
  // ************************************************************
  always_comb begin
    rd_val = 32'h0000_0000;
    if (reg_addr_i >= OFF_BYTES_Q && reg_addr_i < OFF_CONG) begin
      if (reg_addr_i[5:2] < 4'd12)
        rd_val = bq_r[reg_addr_i[5:2]];
    end else if ((reg_addr_i & CONG_MASK) == OFF_CONG) begin
      rd_val = {12'h000, cong_r[reg_addr_i[4:2]*CONG_W +: CONG_W]};
    end else begin
      unique case (reg_addr_i)
        OFF_ABR_PRE:  rd_val = {8'h00, pre_r};
        OFF_RM_TMR:   rd_val = 32'(rm_r);
        OFF_UPD_DAT0: rd_val = dat_r[0];
        OFF_UPD_MSK0: rd_val = msk_r[0];
        OFF_UPD_OP0:  rd_val = {30'h0, busy && !set_r, 1'b0};
        OFF_UPD_DAT1: rd_val = dat_r[1];
        OFF_UPD_MSK1: rd_val = msk_r[1];
        OFF_UPD_OP1:  rd_val = {30'h0, busy && set_r, 1'b0};
        OFF_DROP_SEL: rd_val = {30'h0, drop_r};
        OFF_BW_HI:    rd_val = {16'h0, bw_r[bidx(2'd0, drop_r)]};
        OFF_BW_MED:   rd_val = {16'h0, bw_r[bidx(2'd1, drop_r)]};
        OFF_BW_LOW:   rd_val = {16'h0, bw_r[bidx(2'd2, drop_r)]};
        OFF_TX_HI:    rd_val = tx_r[0];
        OFF_TX_MED:   rd_val = tx_r[1];
        OFF_TX_LOW:   rd_val = tx_r[2];
        OFF_CTRL:     rd_val = {31'h0, cwe_r};
        OFF_STATUS:   rd_val = {24'h0, sts_r};
        OFF_INT_EN:   rd_val = {24'h0, ien_r};
        OFF_TD_PTR:   rd_val = {25'h0, tptr_r};
        OFF_TD_DAT:   rd_val = td_mem[tptr_r];
        OFF_TW_PTR:   rd_val = {18'h0, wptr_r};
        OFF_TW_DAT:   rd_val = {13'h0, tw_mem[wptr_r]};
        OFF_LC_PTR:   rd_val = {26'h0, cptr_r};
        OFF_LC_DAT:   rd_val = lc_mem[cptr_r];
        8'h60, 8'h64, 8'h68:
          rd_val = 32'(fs_r[bidx(reg_addr_i[3:2] - 2'd0, drop_r)]);
        8'h6c, 8'h70, 8'h74:
          rd_val = 32'(ss_r[bidx(reg_addr_i[3:2] - 2'd3, drop_r)]);
        OFF_TSVC:     rd_val = {24'h0, ts_r};
        default:      rd_val = 32'h0000_0000;
      endcase
    end
  end

  // ************************************************************
  // next state
  // ************************************************************
  always_comb begin
    logic [7:0] lim;
    lim = 8'h00;
    // timers
    pre_nxt = pre_r;
    acc_nxt = acc_r + pre_r;
    rm_nxt  = (acc_nxt[ACC_W-1] != acc_r[ACC_W-1]) ? rm_r + 1'b1 : rm_r;
    // update engine
    dat_nxt = dat_r;
    msk_nxt = msk_r;
    st_nxt = st_r;
    set_nxt = set_r;
    uadr_nxt = uadr_r;
    uword_nxt = uword_r;
    lc_we = 1'b0;
    lc_wa = cptr_r;
    lc_wd = reg_wdata_i;
    unique case (st_r)
      UPD_IDLE: if (wr && (reg_addr_i == OFF_UPD_OP0 ||
                           reg_addr_i == OFF_UPD_OP1)) begin
        st_nxt   = UPD_RD;
        set_nxt  = (reg_addr_i == OFF_UPD_OP1);
        uadr_nxt = reg_wdata_i[UPD_IDX_LO +: 6];
      end
      UPD_RD: begin
        uword_nxt = lc_mem[uadr_r];
        st_nxt    = UPD_WR;
      end
      UPD_WR: begin
        lc_we = 1'b1;
        lc_wa = uadr_r;
        lc_wd = merged;
        dat_nxt[set_r] = merged;
        st_nxt = UPD_IDLE;
      end
    endcase
    // banked, counters and limiters
    drop_nxt = drop_r;
    bw_nxt = bw_r;
    tx_nxt = tx_r;
    fs_nxt = fs_r;
    ss_nxt = ss_r;
    ts_nxt = timer_svc_i ? ts_r + 8'h01 : ts_r;
    tp_nxt = (ts_r != timeslot_i[TSVC_HI:TSVC_LO]);
    if (cell_sent_i && cell_prio_i < 2'd3)
      tx_nxt[cell_prio_i] = tx_r[cell_prio_i] + 32'h1;
    for (int i = 0; i < NBANK; i++) begin
      win_nxt[i]  = win_r[i];
      sent_nxt[i] = sent_r[i];
      bq_nxt[i]   = bq_r[i];
      if (cell_time_i) begin
        if (win_r[i] + 8'h01 >= bw_r[i][7:0]) begin
          win_nxt[i]  = 8'h00;
          sent_nxt[i] = 8'h00;
        end else begin
          win_nxt[i] = win_r[i] + 8'h01;
        end
      end
      if (cell_sent_i && bidx(cell_prio_i, cell_drop_i) == 4'(i)) begin
        if (sent_nxt[i] != 8'hff)
          sent_nxt[i] = sent_nxt[i] + 8'h01;
        bq_nxt[i] = bq_nxt[i] - 32'(cell_bytes_i);
      end
      if (enq_i && bidx(enq_prio_i, enq_drop_i) == 4'(i))
        bq_nxt[i] = bq_nxt[i] + 32'(enq_bytes_i);
      lim = bw_r[i][15:BW_CNT_LO];
      if (i < 4)
        allow_nxt[i] = (sent_r[i] < lim) ||
                       !(pend_i[i+4] || pend_i[i+8]);
      else if (i < 8)
        allow_nxt[i] = (sent_r[i] < lim) || !pend_i[i+4];
      else
        allow_nxt[i] = (sent_r[i] < lim);
      fp_nxt[i] = (fs_r[i] != timeslot_i[SVC_W-1:0]);
      sp_nxt[i] = (ss_r[i] != timeslot_i[SVC_W-1:0]);
    end
    for (int p = 0; p < PRIOS; p++) begin
      if (fast_svc_i[p])
        fs_nxt[bidx(2'(p), svc_drop_i)] =
          fs_r[bidx(2'(p), svc_drop_i)] + 1'b1;
      if (slow_svc_i[p])
        ss_nxt[bidx(2'(p), svc_drop_i)] =
          ss_r[bidx(2'(p), svc_drop_i)] + 1'b1;
    end
    // interrupt, congestion, arrays
    cwe_nxt = cwe_r;
    ien_nxt = ien_r;
    sts_nxt = sts_r | sts_evt_i;
    irq_nxt = |(sts_r & ien_r) && central_ien_i;
    cong_nxt = cong_r;
    grp = 8'({cong_qgrp_i, cong_drop_i});
    halt_nxt = (grp < 8'(CONG_GRPS)) ? cong_r[grp] : 1'b0;
    tptr_nxt = tptr_r;
    wptr_nxt = wptr_r;
    cptr_nxt = cptr_r;
    td_we = 1'b0;
    tw_we = 1'b0;
    clr_nxt = clr_r && (cidx_r != 14'(TW_DEPTH - 1));
    cidx_nxt = cidx_r + 14'h0001;
    // bus access
    ack_nxt  = take;
    rdat_nxt = (take && !reg_we_i) ? rd_val : reg_rdata_o;
    if (take && reg_addr_i == OFF_TD_DAT) begin
      td_we    = reg_we_i;
      tptr_nxt = 7'(step(14'(tptr_r), 14'(TD_DEPTH - 1)));
    end
    if (take && reg_addr_i == OFF_TW_DAT) begin
      tw_we    = reg_we_i;
      wptr_nxt = step(wptr_r, 14'(TW_DEPTH - 1));
    end
    if (take && reg_addr_i == OFF_LC_DAT) begin
      lc_we    = reg_we_i;
      cptr_nxt = 6'(step(14'(cptr_r), 14'(LC_DEPTH - 1)));
    end
    if (wr) begin
      if ((reg_addr_i & CONG_MASK) == OFF_CONG) begin
        if (cwe_r)
          cong_nxt[reg_addr_i[4:2]*CONG_W +: CONG_W] =
            reg_wdata_i[CONG_W-1:0];
      end else begin
        unique case (reg_addr_i)
          OFF_ABR_PRE:  pre_nxt = reg_wdata_i[ACC_W-1:0];
          OFF_UPD_DAT0: dat_nxt[0] = reg_wdata_i;
          OFF_UPD_MSK0: msk_nxt[0] = reg_wdata_i;
          OFF_UPD_DAT1: dat_nxt[1] = reg_wdata_i;
          OFF_UPD_MSK1: msk_nxt[1] = reg_wdata_i;
          OFF_DROP_SEL: drop_nxt = reg_wdata_i[1:0];
          OFF_BW_HI, OFF_BW_MED, OFF_BW_LOW:
            bw_nxt[bidx(reg_addr_i[3:2] - 2'd1, drop_r)] =
              reg_wdata_i[15:0];
          OFF_TX_HI:    tx_nxt[0] = reg_wdata_i;
          OFF_TX_MED:   tx_nxt[1] = reg_wdata_i;
          OFF_TX_LOW:   tx_nxt[2] = reg_wdata_i;
          OFF_CTRL:     cwe_nxt = reg_wdata_i[CTRL_CONG_WE];
          // set wins over a software clear
          OFF_STATUS:   sts_nxt = (sts_r & ~reg_wdata_i[STS_W-1:0]) |
                                  sts_evt_i;
          OFF_INT_EN:   ien_nxt = reg_wdata_i[STS_W-1:0];
          OFF_TD_PTR:   tptr_nxt = (reg_wdata_i[6:0] < 7'(TD_DEPTH)) ?
                                   reg_wdata_i[6:0] : 7'h00;
          OFF_TW_PTR:   wptr_nxt = reg_wdata_i[13:0];
          OFF_LC_PTR:   cptr_nxt = reg_wdata_i[5:0];
          8'h60, 8'h64, 8'h68:
            fs_nxt[bidx(reg_addr_i[3:2], drop_r)] =
              reg_wdata_i[SVC_W-1:0];
          8'h6c, 8'h70, 8'h74:
            ss_nxt[bidx(reg_addr_i[3:2] - 2'd3, drop_r)] =
              reg_wdata_i[SVC_W-1:0];
          OFF_TSVC:     ts_nxt = reg_wdata_i[7:0];
          default:      ;
        endcase
      end
    end
  end

  // ************************************************************
  // registers
  // ************************************************************
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      acc_r <= 24'h000000;
      pre_r <= ABR_PRE_RST;
      rm_r  <= '0;
      dat_r <= '{default: 32'h0};
      msk_r <= '{default: 32'h0};
      st_r <= UPD_IDLE;
      set_r <= 1'b0;
      uadr_r <= 6'h00;
      uword_r <= 32'h0;
      drop_r <= 2'h0;
      bw_r <= '{default: BW_RST};
      win_r <= '{default: 8'h00};
      sent_r <= '{default: 8'h00};
      tx_r <= '{default: 32'h0};
      bq_r <= '{default: 32'h0};
      fs_r <= '{default: '0};
      ss_r <= '{default: '0};
      ts_r <= 8'h00;
      cwe_r <= 1'b0;
      sts_r <= '0;
      ien_r <= '0;
      tptr_r <= 7'h00;
      wptr_r <= 14'h0000;
      cptr_r <= 6'h00;
      cong_r <= '0;
      clr_r <= 1'b1;
      cidx_r <= 14'h0000;
      reg_ack_o <= 1'b0;
      reg_rdata_o <= 32'h0;
      allow_o <= 12'h000;
      fast_pend_o <= 12'h000;
      slow_pend_o <= 12'h000;
      timer_pend_o <= 1'b0;
      halt_o <= 1'b0;
      irq_o <= 1'b0;
    end else begin
      acc_r <= acc_nxt;
      pre_r <= pre_nxt;
      rm_r <= rm_nxt;
      dat_r <= dat_nxt;
      msk_r <= msk_nxt;
      st_r <= st_nxt;
      set_r <= set_nxt;
      uadr_r <= uadr_nxt;
      uword_r <= uword_nxt;
      drop_r <= drop_nxt;
      bw_r <= bw_nxt;
      win_r <= win_nxt;
      sent_r <= sent_nxt;
      tx_r <= tx_nxt;
      bq_r <= bq_nxt;
      fs_r <= fs_nxt;
      ss_r <= ss_nxt;
      ts_r <= ts_nxt;
      cwe_r <= cwe_nxt;
      sts_r <= sts_nxt;
      ien_r <= ien_nxt;
      tptr_r <= tptr_nxt;
      wptr_r <= wptr_nxt;
      cptr_r <= cptr_nxt;
      cong_r <= cong_nxt;
      clr_r <= clr_nxt;
      cidx_r <= cidx_nxt;
      reg_ack_o <= ack_nxt;
      reg_rdata_o <= rdat_nxt;
      allow_o <= allow_nxt;
      fast_pend_o <= fp_nxt;
      slow_pend_o <= sp_nxt;
      timer_pend_o <= tp_nxt;
      halt_o <= halt_nxt;
      irq_o <= irq_nxt;
    end
  end

  assign rm_timer_o = rm_r;
  assign clearing_o = clr_r;

  // ************************************************************
  // arrays
  // ************************************************************
  // no reset on the arrays: the sweep is what clears them
  always_ff @(posedge sys_clk_i) begin
    if (clr_r) begin
      tw_mem[cidx_r] <= '0;
      if (cidx_r < 14'(TD_DEPTH))
        td_mem[cidx_r[6:0]] <= 32'h0;
      if (cidx_r < 14'(LC_DEPTH))
        lc_mem[cidx_r[5:0]] <= 32'h0;
    end else begin
      if (td_we)
        td_mem[tptr_r] <= reg_wdata_i;
      if (tw_we)
        tw_mem[wptr_r] <= reg_wdata_i[TW_W-1:0];
      if (lc_we)
        lc_mem[lc_wa] <= lc_wd;
    end
  end

endmodule

// file: bench/cssr_checker.sv
// Purpose: port-level assertions for cssr_top
// Assumes: one clock, srst_i synchronous and active high
// Notes:   sees top ports only; attached by bind from the bench
`timescale 1ns/1ps
module cssr_checker #(
  parameter int RM_W = 16
) (
  input wire logic            sys_clk_i,
  input wire logic            srst_i,
  input wire logic            reg_req_i,
  input wire logic            reg_we_i,
  input wire logic [7:0]      reg_addr_i,
  input wire logic            reg_ack_o,
  input wire logic [31:0]     reg_rdata_o,
  input wire logic [RM_W-1:0] rm_timer_o,
  input wire logic [5:0]      cong_qgrp_i,
  input wire logic            central_ien_i,
  input wire logic            halt_o,
  input wire logic            irq_o,
  input wire logic            clearing_o
);
  import cssr_pkg::*;
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (srst_i);
  // ****************
  // properties
  // ****************
  a_ack_one_cycle: assert property (reg_ack_o |=> !reg_ack_o)
    else $error("ack longer than one cycle");
  a_ack_has_req: assert property (reg_ack_o |-> $past(reg_req_i))
    else $error("ack without request");
  a_rdata_held: assert property (!reg_ack_o |-> $stable(reg_rdata_o))
    else $error("read data moved without ack");
  a_op_bit_zero: assert property (reg_ack_o && !$past(reg_we_i) &&
    $past(reg_addr_i) == OFF_UPD_OP0 |-> !reg_rdata_o[0])
    else $error("operation read bit 0 set");
  // the timer has no write path; steps are still judged only between accesses
  a_rm_step: assert property (!$past(reg_req_i) &&
    rm_timer_o != $past(rm_timer_o) |->
    rm_timer_o == RM_W'($past(rm_timer_o) + 1))
    else $error("rm timer jumped");
  a_irq_gated: assert property (irq_o |-> $past(central_ien_i))
    else $error("irq without central enable");
  a_halt_range: assert property ($past(cong_qgrp_i) >= 6'd40 |-> !halt_o)
    else $error("halt for group beyond range");
  a_clear_once: assert property (!$past(clearing_o) |-> !clearing_o)
    else $error("array sweep restarted");
endmodule

// file: bench/cssr_top_tb_top.sv
// Purpose: self-checking bench for cssr_top
// Assumes: inputs change on the falling clock edge
// Notes:   the post-reset array sweep dominates run time
`timescale 1ns/1ps
bind cssr_top cssr_checker #(.RM_W(RM_W)) i_cssr_checker (
  .sys_clk_i(sys_clk_i), .srst_i(srst_i), .reg_req_i(reg_req_i),
  .reg_we_i(reg_we_i), .reg_addr_i(reg_addr_i), .reg_ack_o(reg_ack_o),
  .reg_rdata_o(reg_rdata_o), .rm_timer_o(rm_timer_o),
  .cong_qgrp_i(cong_qgrp_i), .central_ien_i(central_ien_i),
  .halt_o(halt_o), .irq_o(irq_o), .clearing_o(clearing_o));
module cssr_top_tb_top;
  import cssr_pkg::*;
  typedef struct {logic w; logic [7:0] a; logic [31:0] d, e;} cssr_row_t;
  logic        clk = 0, rst = 1, req = 0, we = 0, ack, tp, halt, irq, clr;
  logic        ct = 0, cs = 0, en = 0, tsv = 0, cen = 0;
  logic [1:0]  cp = 0, cd = 0, ep = 0, ed = 0, sd = 0, qd = 0;
  logic [2:0]  fs = 0, ss = 0;
  logic [5:0]  qg = 0;
  logic [7:0]  addr = 0, sts = 0;
  logic [11:0] pend = 0, allow, fp, sp;
  logic [15:0] cb = 0, eb = 0, rm, v;
  logic [22:0] ts = 23'h8005;
  logic [31:0] wd = 0, rd, rv;
  int          error_cnt = 0, n_checks = 0;
  cssr_top i_cssr_top (.sys_clk_i(clk), .srst_i(rst), .reg_req_i(req),
    .reg_we_i(we), .reg_addr_i(addr), .reg_wdata_i(wd), .reg_ack_o(ack),
    .reg_rdata_o(rd), .timeslot_i(ts), .cell_time_i(ct), .cell_sent_i(cs),
    .cell_prio_i(cp), .cell_drop_i(cd), .cell_bytes_i(cb), .enq_i(en),
    .enq_prio_i(ep), .enq_drop_i(ed), .enq_bytes_i(eb), .pend_i(pend),
    .fast_svc_i(fs), .slow_svc_i(ss), .svc_drop_i(sd), .timer_svc_i(tsv),
    .cong_qgrp_i(qg), .cong_drop_i(qd), .sts_evt_i(sts),
    .central_ien_i(cen), .rm_timer_o(rm), .allow_o(allow),
    .fast_pend_o(fp), .slow_pend_o(sp), .timer_pend_o(tp), .halt_o(halt),
    .irq_o(irq), .clearing_o(clr));
  always #5 clk = ~clk;
  // ****************
  // tasks
  // ****************
  task automatic chk(string n, logic [31:0] g, logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // request held until ack is seen, released on the next falling edge
  task automatic acc(logic w, logic [7:0] a, logic [31:0] d);
    int k;
    k = 0;
    @(negedge clk);
    req = 1;
    we = w;
    addr = a;
    wd = d;
    do begin @(posedge clk); k++; end while (ack !== 1'b1 && k < 99);
    chk("ack", {31'h0, ack}, 1);
    rv = rd;
    @(negedge clk);
    req = 0;
  endtask
  task automatic w3;
    repeat (3) @(negedge clk);
  endtask
  cssr_row_t rows[27] = '{
    '{0, OFF_ABR_PRE, 0, 32'h142}, '{1, OFF_DROP_SEL, 1, 0},
    '{1, OFF_BW_HI, 32'h203, 0}, '{0, OFF_BW_HI, 0, 32'h203},
    '{1, OFF_DROP_SEL, 0, 0}, '{0, OFF_BW_HI, 0, 32'hff01},
    '{1, OFF_TD_PTR, 32'h5f, 0}, '{1, OFF_TD_DAT, 32'ha5, 0},
    '{1, OFF_TD_DAT, 32'h5a, 0}, '{1, OFF_TD_PTR, 32'h5f, 0},
    '{0, OFF_TD_DAT, 0, 32'ha5}, '{0, OFF_TD_DAT, 0, 32'h5a},
    '{1, OFF_LC_PTR, 5, 0}, '{1, OFF_LC_DAT, 32'hffff, 0},
    '{1, OFF_UPD_MSK0, 32'hff00ff, 0}, '{1, OFF_UPD_DAT0, 32'h12345678, 0},
    '{1, OFF_UPD_OP0, 32'h14, 0}, '{0, OFF_UPD_DAT0, 0, 32'h34ff78},
    '{0, OFF_UPD_OP0, 0, 0}, '{1, OFF_UPD_MSK1, 32'hffffffff, 0},
    '{1, OFF_UPD_DAT1, 32'hcafe0001, 0}, '{1, OFF_UPD_OP1, 32'h18, 0},
    '{1, OFF_LC_PTR, 5, 0}, '{0, OFF_LC_DAT, 0, 32'h34ff78},
    '{0, OFF_LC_DAT, 0, 32'hcafe0001}, '{0, 8'hb0, 0, 0},
    '{1, OFF_ABR_PRE, 32'h800000, 0}};
  initial begin
    #400000;
    error_cnt++;
    conclude();
  end
  initial begin
    repeat (20) @(negedge clk);
    rst = 0;
    for (int k = 0; k < 20000 && clr !== 1'b0; k++) @(negedge clk);
    foreach (rows[i]) begin
      acc(rows[i].w, rows[i].a, rows[i].d);
      if (!rows[i].w) chk($sformatf("row %0d", i), rv, rows[i].e);
    end
    $display("register table done");
    // prescaler at half the accumulator span: one tick per clock
    v = rm;
    repeat (16) @(negedge clk);
    chk("rm_timer", {16'h0, rm}, {16'h0, 16'(v + 16'h10)});
    for (int p = 0; p < 3; p++) begin
      @(negedge clk);
      {en, ep, ed, eb} = {1'b1, 2'(p), 2'h3, 16'h64};
      @(negedge clk);
      {en, cs, cp, cd, cb} = {1'b0, 1'b1, 2'(p), 2'h3, 16'ha};
      repeat (p + 1) @(negedge clk);
      cs = 0;
      acc(0, 8'(OFF_TX_HI + 4 * p), 0);
      chk("cells_tx", rv, 32'(p + 1));
      acc(0, 8'(OFF_BYTES_Q + 16 * p + 12), 0);
      chk("bytes_q", rv, 32'(90 - 10 * p));
    end
    $display("counters done");
    acc(1, OFF_BW_MED, 32'h104);
    acc(1, OFF_BW_LOW, 32'h104);
    pend = 12'h0ff;
    for (int p = 1; p < 3; p++) begin
      @(negedge clk);
      {cs, cp, cd, cb} = {1'b1, 2'(p), 2'h0, 16'h0};
      @(negedge clk);
      cs = 0;
    end
    w3();
    chk("allow_med_waived", {31'h0, allow[4]}, 1);
    chk("allow_low", {31'h0, allow[8]}, 0);
    pend = 12'hfff;
    w3();
    chk("allow_med", {31'h0, allow[4]}, 0);
    ct = 1;
    repeat (4) @(negedge clk);
    ct = 0;
    w3();
    chk("allow_window", {31'h0, allow[8]}, 1);
    $display("limiters done");
    acc(1, OFF_FSVC_HI, 32'h8004);
    w3();
    chk("fast_pend", {31'h0, fp[0]}, 1);
    chk("slow_pend", {31'h0, sp[0]}, 1);
    fs = 3'h1;
    @(negedge clk);
    fs = 0;
    w3();
    chk("fast_pend", {31'h0, fp[0]}, 0);
    acc(1, OFF_TSVC, 1);
    w3();
    chk("timer_pend", {31'h0, tp}, 0);
    tsv = 1;
    @(negedge clk);
    tsv = 0;
    w3();
    chk("timer_pend", {31'h0, tp}, 1);
    $display("serviced counters done");
    acc(1, OFF_INT_EN, 1);
    sts = 8'h1;
    @(negedge clk);
    sts = 0;
    w3();
    chk("irq_central_off", {31'h0, irq}, 0);
    cen = 1;
    w3();
    chk("irq", {31'h0, irq}, 1);
    acc(1, OFF_STATUS, 1);
    w3();
    chk("irq_cleared", {31'h0, irq}, 0);
    $display("interrupt done");
    acc(1, OFF_CTRL, 1);
    acc(1, 8'hc8, 32'h20);
    {qg, qd} = {6'hb, 2'h1};
    w3();
    chk("halt", {31'h0, halt}, 1);
    {qg, qd} = {6'h28, 2'h0};
    w3();
    chk("halt_range", {31'h0, halt}, 0);
    acc(1, OFF_CTRL, 0);
    acc(1, 8'hc8, 0);
    acc(0, 8'hc8, 0);
    chk("cong_locked", rv, 32'h20);
    $display("congestion done");
    conclude();
  end
endmodule
